// [opc_pkg.sv]
// Constants for the twelve-bit output port with special clock outputs.
// Notes on behaviour
// - Twelve output bits in three four-bit groups.
// - Reset sets data to one, float to zero.
// - Float one floats pins, zero drives data.
// - Group zero per-bit float; groups one, two shared.
// - Unfloated pins follow data; data is read/write.
// - Bit two timer clock, bit three frequency clock.
// - Data zero forces low even with clock selected.
// - Float one still floats a clock output.
// - Timer clock passes while its enable is one.
// - Select picks fast, slow, slow/8, slow/64.
// - Group zero float bits, bits two/three float clocks.
// - Group one data and float register layout.
// - Disabled clock output drives high.
// - Timer clock enable register bit two, resets zero.
// - Group two data and float register layout.
package opc_pkg;
  localparam int APB_ADDR_W = 18;
  localparam int GROUP_W = 4;
  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_FREQ_CTRL = 16'hFF06;
  localparam logic [15:0] IDX_G0_FLOAT = 16'hFF30;
  localparam logic [15:0] IDX_G0_DATA = 16'hFF31;
  localparam logic [15:0] IDX_G1_FLOAT = 16'hFF32;
  localparam logic [15:0] IDX_G1_DATA = 16'hFF33;
  localparam logic [15:0] IDX_G2_FLOAT = 16'hFF34;
  localparam logic [15:0] IDX_G2_DATA = 16'hFF35;
  localparam logic [15:0] IDX_TIMER_CTRL = 16'hFFC1;
  // Field positions.
  localparam int FREQ_ENABLE_BIT = 3;
  localparam int FREQ_SEL_LO = 0;
  localparam int FREQ_SEL_HI = 1;
  localparam int TIMER_ENABLE_BIT = 2;
  localparam int GROUP_FLOAT_BIT = 0;
  localparam int TIMER_PIN_BIT = 2;
  localparam int FREQ_PIN_BIT = 3;
  // Reset values.
  localparam logic [3:0] DATA_RESET = 4'hF;
  localparam logic [3:0] FLOAT_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [1:0] FREQ_SEL_RESET = 2'h0;
  // Frequency select codes.
  localparam logic [1:0] SEL_HIGH_SPEED = 2'h3;
  localparam logic [1:0] SEL_LOW_SPEED = 2'h2;
  localparam logic [1:0] SEL_LOW_DIV8 = 2'h1;
  localparam logic [1:0] SEL_LOW_DIV64 = 2'h0;
  // Divider taps on the slow-clock edge counter.
  localparam int DIV_W = 6;
  localparam int DIV8_TAP = 2;
  localparam int DIV64_TAP = 5;
endpackage

// [opc_output_port.sv]
// Twelve-bit output port with timer and frequency clock outputs on an APB slave.
`timescale 1ns/1ns
`default_nettype none
module opc_output_port #(
  parameter int ADDR_W = opc_pkg::APB_ADDR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timerClockIn,
  input wire logic lowSpeedClock,
  input wire logic highSpeedClock,
  output logic [3:0] group0Outputs,
  output logic [3:0] group0OutputsOe,
  output logic [3:0] group1Outputs,
  output logic [3:0] group1OutputsOe,
  output logic [3:0] group2Outputs,
  output logic [3:0] group2OutputsOe
);

  generate
    if (ADDR_W < opc_pkg::APB_ADDR_W) begin : gAddrCheck
      $error("ADDR_W too narrow for the register map.");
    end
  endgenerate

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic logic pickClock(input logic [1:0] sel, input logic hs, input logic ls,
                                     input logic d8, input logic d64);
    case (sel)
      opc_pkg::SEL_HIGH_SPEED: pickClock = hs;
      opc_pkg::SEL_LOW_SPEED: pickClock = ls;
      opc_pkg::SEL_LOW_DIV8: pickClock = d8;
      default: pickClock = d64;
    endcase
  endfunction

  logic [3:0] group0Data;
  logic [3:0] group0Float;
  logic [3:0] group1Data;
  logic group1Float;
  logic [3:0] group2Data;
  logic group2Float;
  logic freqClockOutEnable;
  logic [1:0] freqSelect;
  logic timerClockOutEnable;

  logic accessDone;
  logic wrStrobe;
  logic setupPhase;
  logic mapped;
  logic [3:0] next_readData;

  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign wrStrobe = accessDone & pwrite & ~pslverr;

  assign mapped = hit(paddr, opc_pkg::IDX_FREQ_CTRL) | hit(paddr, opc_pkg::IDX_G0_FLOAT)
    | hit(paddr, opc_pkg::IDX_G0_DATA) | hit(paddr, opc_pkg::IDX_G1_FLOAT)
    | hit(paddr, opc_pkg::IDX_G1_DATA) | hit(paddr, opc_pkg::IDX_G2_FLOAT)
    | hit(paddr, opc_pkg::IDX_G2_DATA) | hit(paddr, opc_pkg::IDX_TIMER_CTRL);

  // Unused positions read as zero.
  always_comb begin
    next_readData = 4'h0;
    if (hit(paddr, opc_pkg::IDX_FREQ_CTRL)) begin
      next_readData[opc_pkg::FREQ_ENABLE_BIT] = freqClockOutEnable;
      next_readData[opc_pkg::FREQ_SEL_HI] = freqSelect[1];
      next_readData[opc_pkg::FREQ_SEL_LO] = freqSelect[0];
    end else if (hit(paddr, opc_pkg::IDX_G0_FLOAT)) begin
      next_readData = group0Float;
    end else if (hit(paddr, opc_pkg::IDX_G0_DATA)) begin
      next_readData = group0Data;
    end else if (hit(paddr, opc_pkg::IDX_G1_FLOAT)) begin
      next_readData[opc_pkg::GROUP_FLOAT_BIT] = group1Float;
    end else if (hit(paddr, opc_pkg::IDX_G1_DATA)) begin
      next_readData = group1Data;
    end else if (hit(paddr, opc_pkg::IDX_G2_FLOAT)) begin
      next_readData[opc_pkg::GROUP_FLOAT_BIT] = group2Float;
    end else if (hit(paddr, opc_pkg::IDX_G2_DATA)) begin
      next_readData = group2Data;
    end else if (hit(paddr, opc_pkg::IDX_TIMER_CTRL)) begin
      next_readData[opc_pkg::TIMER_ENABLE_BIT] = timerClockOutEnable;
    end
  end

  // Answer is prepared in the setup cycle so that every access takes no wait state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      if (setupPhase) begin
        pslverr <= ~mapped;
        prdata <= {28'h000_0000, next_readData};
      end else if (accessDone) begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      group0Data <= opc_pkg::DATA_RESET;
      group1Data <= opc_pkg::DATA_RESET;
      group2Data <= opc_pkg::DATA_RESET;
    end else if (wrStrobe) begin
      if (hit(paddr, opc_pkg::IDX_G0_DATA)) begin
        group0Data <= pwdata[3:0];
      end
      if (hit(paddr, opc_pkg::IDX_G1_DATA)) begin
        group1Data <= pwdata[3:0];
      end
      if (hit(paddr, opc_pkg::IDX_G2_DATA)) begin
        group2Data <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      group0Float <= opc_pkg::FLOAT_RESET;
      group1Float <= opc_pkg::FLAG_RESET;
      group2Float <= opc_pkg::FLAG_RESET;
    end else if (wrStrobe) begin
      if (hit(paddr, opc_pkg::IDX_G0_FLOAT)) begin
        group0Float <= pwdata[3:0];
      end
      if (hit(paddr, opc_pkg::IDX_G1_FLOAT)) begin
        group1Float <= pwdata[opc_pkg::GROUP_FLOAT_BIT];
      end
      if (hit(paddr, opc_pkg::IDX_G2_FLOAT)) begin
        group2Float <= pwdata[opc_pkg::GROUP_FLOAT_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freqClockOutEnable <= opc_pkg::FLAG_RESET;
      freqSelect <= opc_pkg::FREQ_SEL_RESET;
      timerClockOutEnable <= opc_pkg::FLAG_RESET;
    end else if (wrStrobe) begin
      if (hit(paddr, opc_pkg::IDX_FREQ_CTRL)) begin
        freqClockOutEnable <= pwdata[opc_pkg::FREQ_ENABLE_BIT];
        freqSelect <= {pwdata[opc_pkg::FREQ_SEL_HI], pwdata[opc_pkg::FREQ_SEL_LO]};
      end
      if (hit(paddr, opc_pkg::IDX_TIMER_CTRL)) begin
        timerClockOutEnable <= pwdata[opc_pkg::TIMER_ENABLE_BIT];
      end
    end
  end

  // The clock sources come from other domains; bit 0 timer, 1 slow, 2 fast.
  logic [2:0] clkMeta;
  logic [2:0] clkSync;
  logic lowPrev;
  logic [opc_pkg::DIV_W-1:0] lowDivider;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkMeta <= 3'h0;
      clkSync <= 3'h0;
    end else begin
      clkMeta <= {highSpeedClock, lowSpeedClock, timerClockIn};
      clkSync <= clkMeta;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowPrev <= 1'b0;
      lowDivider <= '0;
    end else begin
      lowPrev <= clkSync[1];
      if (clkSync[1] & ~lowPrev) begin
        lowDivider <= lowDivider + 1'b1;
      end
    end
  end

  logic freqSelEffLo;
  logic freqSelEffHi;
  logic freqSource;
  logic freqCandidate;
  logic freqGate;
  logic timerGate;

  assign freqSource = pickClock({freqSelEffHi, freqSelEffLo}, clkSync[2], clkSync[1],
                                lowDivider[opc_pkg::DIV8_TAP], lowDivider[opc_pkg::DIV64_TAP]);
  assign freqCandidate = pickClock(freqSelect, clkSync[2], clkSync[1],
                                   lowDivider[opc_pkg::DIV8_TAP], lowDivider[opc_pkg::DIV64_TAP]);

  // Gates and source changes move only while the clocks are high, where an idle output is
  // also high, so no short pulse can reach the pin. The cost is a delay of up to one period.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freqSelEffLo <= opc_pkg::FREQ_SEL_RESET[0];
      freqSelEffHi <= opc_pkg::FREQ_SEL_RESET[1];
      freqGate <= 1'b0;
    end else begin
      if (freqSource) begin
        freqGate <= freqClockOutEnable;
      end
      if ((~freqGate | freqSource) & freqCandidate) begin
        freqSelEffLo <= freqSelect[0];
        freqSelEffHi <= freqSelect[1];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerGate <= 1'b0;
    end else if (clkSync[0]) begin
      timerGate <= timerClockOutEnable;
    end
  end

  logic timerPinValue;
  logic freqPinValue;

  // A disabled clock output idles high; a data bit of zero still pulls the pin low.
  assign timerPinValue = group0Data[opc_pkg::TIMER_PIN_BIT] & (~timerGate | clkSync[0]);
  assign freqPinValue = group0Data[opc_pkg::FREQ_PIN_BIT] & (~freqGate | freqSource);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      group0Outputs <= opc_pkg::DATA_RESET;
      group1Outputs <= opc_pkg::DATA_RESET;
      group2Outputs <= opc_pkg::DATA_RESET;
      group0OutputsOe <= 4'hF;
      group1OutputsOe <= 4'hF;
      group2OutputsOe <= 4'hF;
    end else begin
      group0Outputs <= {freqPinValue, timerPinValue, group0Data[1:0]};
      group1Outputs <= group1Data;
      group2Outputs <= group2Data;
      group0OutputsOe <= ~group0Float;
      group1OutputsOe <= {4{~group1Float}};
      group2OutputsOe <= {4{~group2Float}};
    end
  end

endmodule
`default_nettype wire

// [opc_output_port_checker.sv]
// Checker for the output port's bus answers and pin behaviour.
`timescale 1ns/1ns
`default_nettype none
module opc_output_port_checker #(
  parameter int ADDR_W = opc_pkg::APB_ADDR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timerClockIn,
  input wire logic lowSpeedClock,
  input wire logic highSpeedClock,
  input wire logic [3:0] group0Outputs,
  input wire logic [3:0] group0OutputsOe,
  input wire logic [3:0] group1Outputs,
  input wire logic [3:0] group1OutputsOe,
  input wire logic [3:0] group2Outputs,
  input wire logic [3:0] group2OutputsOe
);
  logic wrDone;
  assign wrDone = psel && penable && pready && pwrite && !pslverr;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready in the access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without a setup cycle");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside the access cycle");
  a_rdata_unused: assert property (prdata[31:4] == 28'h000_0000)
    else $error("unused read bits not zero");
  a_err_silent: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer carries data");
  a_shared_float: assert property ((&group1OutputsOe || !(|group1OutputsOe))
      && (&group2OutputsOe || !(|group2OutputsOe)))
    else $error("group enable split");
  a_group0_data: assert property (wrDone && paddr == {opc_pkg::IDX_G0_DATA, 2'b00}
      |=> ##1 group0Outputs[1:0] == $past(pwdata[1:0], 2))
    else $error("group0 pins not following data");
  a_group1_data: assert property (wrDone && paddr == {opc_pkg::IDX_G1_DATA, 2'b00}
      |=> ##1 group1Outputs == $past(pwdata[3:0], 2))
    else $error("group1 pins not following data");
  a_group1_float: assert property (wrDone && paddr == {opc_pkg::IDX_G1_FLOAT, 2'b00}
      |=> ##1 group1OutputsOe == {4{~$past(pwdata[0], 2)}})
    else $error("group1 float not applied");
endmodule
bind opc_output_port opc_output_port_checker #(.ADDR_W(ADDR_W)) i_checker (.clk(clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerClockIn(timerClockIn),
  .lowSpeedClock(lowSpeedClock), .highSpeedClock(highSpeedClock),
  .group0Outputs(group0Outputs), .group0OutputsOe(group0OutputsOe),
  .group1Outputs(group1Outputs), .group1OutputsOe(group1OutputsOe),
  .group2Outputs(group2Outputs), .group2OutputsOe(group2OutputsOe));
`default_nettype wire

// [opc_clock_sources.sv]
// Free-running timer and oscillator clocks, unrelated in phase to the system clock.
`timescale 1ns/1ns
`default_nettype none
module opc_clock_sources #(
  parameter int TIMER_HALF = 64,
  parameter int SLOW_HALF = 40,
  parameter int FAST_HALF = 24
) (
  output logic timerClockIn,
  output logic lowSpeedClock,
  output logic highSpeedClock
);
  initial begin
    timerClockIn = 1'b0;
    #1;
    forever #TIMER_HALF timerClockIn = !timerClockIn;
  end
  initial begin
    lowSpeedClock = 1'b0;
    #3;
    forever #SLOW_HALF lowSpeedClock = !lowSpeedClock;
  end
  // The fast oscillator starts toggling after a 2 ns offset, so it is stable before anyone selects it.
  initial begin
    highSpeedClock = 1'b0;
    #2;
    forever #FAST_HALF highSpeedClock = !highSpeedClock;
  end
endmodule
`default_nettype wire

// [output_port_with_clock_out_tb.sv]
// Self-checking bench for the output port.
`timescale 1ns/1ns
`default_nettype none
module output_port_with_clock_out_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, e, tc, sc, fc;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] g0, g0e, g1, g1e, g2, g2e;
  int errors = 0;
  int n_compared = 0;
  int n, h;
  localparam logic [15:0] IDX [8] = '{16'hFF06, 16'hFF30, 16'hFF31, 16'hFF32, 16'hFF33,
    16'hFF34, 16'hFF35, 16'hFFC1};
  localparam logic [3:0] RST_V [8] = '{4'h0, 4'h0, 4'hF, 4'h0, 4'hF, 4'h0, 4'hF, 4'h0};
  localparam logic [3:0] ONE_V [8] = '{4'hB, 4'hF, 4'hF, 4'h1, 4'hF, 4'h1, 4'hF, 4'h4};
  localparam int FREQ_N [4] = '{2, 16, 128, 213};
  opc_clock_sources i_src (.timerClockIn(tc), .lowSpeedClock(sc), .highSpeedClock(fc));
  opc_output_port i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerClockIn(tc), .lowSpeedClock(sc), .highSpeedClock(fc),
    .group0Outputs(g0), .group0OutputsOe(g0e), .group1Outputs(g1), .group1OutputsOe(g1e),
    .group2Outputs(g2), .group2OutputsOe(g2e));
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    chk(32'(k), 32'h0000_0001);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cnt(input int b);
    logic p;
    n = 0;
    h = 0;
    p = g0[b];
    repeat (1280) begin
      @(posedge clk);
      n += int'(g0[b] && !p);
      h += int'(g0[b]);
      p = g0[b];
    end
  endtask
  task automatic t_regs();
    foreach (IDX[i]) begin
      apb(1'b0, IDX[i], 32'h0000_0000);
      chk(r, {28'h0, RST_V[i]});
    end
    foreach (IDX[i]) apb(1'b1, IDX[i], 32'hFFFF_FFFF);
    foreach (IDX[i]) begin
      apb(1'b0, IDX[i], 32'h0000_0000);
      chk(r, {28'h0, ONE_V[i]});
    end
    chk({20'h0, g2e, g1e, g0e}, 32'h0000_0000);
    foreach (IDX[i]) apb(1'b1, IDX[i], 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk({8'h0, g2, g1, g0, g2e, g1e, g0e}, 32'h0000_0FFF);
    apb(1'b1, 16'hFF07, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h0000_0001);
    apb(1'b0, 16'hFF07, 32'h0000_0000);
    chk({e, r[30:0]}, 32'h8000_0000);
  endtask
  task automatic t_pins();
    apb(1'b1, 16'hFF30, 32'h0000_0006);
    apb(1'b1, 16'hFF31, 32'h0000_0009);
    apb(1'b1, 16'hFF33, 32'h0000_000A);
    apb(1'b1, 16'hFF34, 32'h0000_0001);
    apb(1'b1, 16'hFF35, 32'h0000_0005);
    repeat (2) @(posedge clk);
    chk({8'h0, g2, g1, g0, g2e, g1e, g0e}, 32'h005A_90F9);
    apb(1'b1, 16'hFF30, 32'h0000_0000);
    apb(1'b1, 16'hFF31, 32'h0000_000F);
  endtask
  task automatic t_freq();
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 16'hFF06, {28'h0, 2'b10, 2'(s)});
      repeat (700) @(posedge clk);
      cnt(3);
      if (n == FREQ_N[s] - 1 || n == FREQ_N[s] + 1) n = FREQ_N[s];
      chk(32'(n), 32'(FREQ_N[s]));
    end
    apb(1'b1, 16'hFF06, 32'h0000_0003);
    repeat (100) @(posedge clk);
    cnt(3);
    chk(32'(h), 32'h0000_0500);
    apb(1'b1, 16'hFF06, 32'h0000_000B);
    apb(1'b1, 16'hFF31, 32'h0000_0007);
    repeat (100) @(posedge clk);
    cnt(3);
    chk(32'(h), 32'h0000_0000);
    apb(1'b1, 16'hFF30, 32'h0000_0008);
    repeat (2) @(posedge clk);
    chk({28'h0, g0e}, 32'h0000_0007);
    apb(1'b1, 16'hFF30, 32'h0000_0000);
    apb(1'b1, 16'hFF31, 32'h0000_000F);
    apb(1'b1, 16'hFF06, 32'h0000_0000);
  endtask
  task automatic t_timer();
    apb(1'b1, 16'hFFC1, 32'h0000_0004);
    repeat (100) @(posedge clk);
    cnt(2);
    if (n == 79 || n == 81) n = 80;
    chk(32'(n), 32'h0000_0050);
    apb(1'b1, 16'hFFC1, 32'h0000_0000);
    repeat (100) @(posedge clk);
    cnt(2);
    chk(32'(h), 32'h0000_0500);
  endtask
  task automatic give_verdict();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0_0000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge clk);
    chk({8'h0, g2, g1, g0, g2e, g1e, g0e}, 32'h00FF_FFFF);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_pins();
    t_freq();
    t_timer();
    give_verdict();
  end
  // Sized well above the roughly fourteen thousand cycles that the scenarios take.
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
